// ==== verilog/psbs_pkg.sv ====
// Constants, types and state record of the power state and boot sequencer
package psbs_pkg;

  localparam int unsigned CLK_NS       = 10;
  localparam int unsigned ENTER_NS     = 40;
  localparam int unsigned ENTER_CYC    = (ENTER_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0]  ENTER_CNT    = 3'(ENTER_CYC - 1);

  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_CG_MASK  = 8'h04;
  localparam logic [7:0]  OFF_RET_EN   = 8'h08;
  localparam logic [7:0]  OFF_PWR_EN   = 8'h0c;
  localparam logic [7:0]  OFF_MODE     = 8'h10;
  localparam logic [7:0]  OFF_REMAP    = 8'h14;
  localparam logic [7:0]  OFF_VECTOR   = 8'h18;
  localparam logic [7:0]  OFF_STATUS   = 8'h1c;
  localparam logic [7:0]  OFF_FUSE     = 8'h20;
  localparam logic [7:0]  OFF_HDR0     = 8'h24;

  localparam int unsigned CTRL_SLEEP   = 0;
  localparam int unsigned CTRL_OFF     = 1;
  localparam int unsigned CTRL_SLOW    = 2;
  localparam int unsigned CTRL_RTC     = 3;
  localparam int unsigned CTRL_DONE    = 4;
  localparam int unsigned FUSE_PROG    = 0;
  localparam int unsigned FUSE_READ    = 1;
  localparam int unsigned FUSE_DATA    = 16;
  localparam int unsigned FUSE_RVAL    = 16;

  localparam int unsigned WK_PIN       = 0;
  localparam int unsigned WK_RTC       = 1;
  localparam int unsigned WK_RST       = 2;
  localparam int unsigned WK_UVLO      = 3;

  localparam int unsigned SRAM_BLOCKS  = 5;
  localparam int unsigned PWR_DOMAINS  = 6;

  // Flash header word offsets: mode, image base, image_length, boot selector
  localparam logic [3:0]  HDR_MODE     = 4'h0;
  localparam logic [3:0]  HDR_BASE     = 4'h4;
  localparam logic [3:0]  HDR_LEN      = 4'h8;
  localparam logic [3:0]  HDR_BOOT     = 4'hc;

  // Retained SRAM supply codes: 1.2V, lowered, removed
  localparam logic [1:0]  SUP_FULL     = 2'h2;
  localparam logic [1:0]  SUP_RET      = 2'h1;
  localparam logic [1:0]  SUP_OFF      = 2'h0;

  localparam logic [4:0]  RST_RET_EN   = 5'h00;
  localparam logic [5:0]  RST_PWR_EN   = 6'h3f;
  localparam logic [1:0]  RST_CG_MASK  = 2'h3;

  typedef enum logic [5:0] {
    ST_NORMAL = 6'h01,
    ST_CGATE  = 6'h02,
    ST_ENTER  = 6'h04,
    ST_SLEEP  = 6'h08,
    ST_OFF    = 6'h10,
    ST_BOOT   = 6'h20
  } psbs_state_e;

  typedef struct packed {
    logic                         fast_rc_oscillator;
    logic                         slow_rc_oscillator;
    logic                         bandgap;
    logic                         low_dropout_regulator;
    logic                         rtc;
    logic [SRAM_BLOCKS-1:0][1:0]  sram_supply;
    logic [PWR_DOMAINS-1:0]       domain_on;
  } psbs_pwr_s;

  typedef struct packed {
    logic       strobe;
    logic       prog;
    logic [7:0] addr;
    logic       wdata;
  } psbs_fuse_s;

  typedef struct packed {
    psbs_state_e       state;
    logic [2:0]        cnt;
    logic              wake_pend;
    logic              off_sel;
    logic [3:0]        s1;
    logic [3:0]        s2;
    logic [3:0]        s3;
    logic [3:0]        wk;
    logic              strap_done;
    logic              probe;
    logic [1:0]        cg_mask;
    logic              keep_slow;
    logic              keep_rtc;
    logic [4:0]        ret_en;
    logic [5:0]        pwr_en;
    logic [31:0]       mode;
    logic [31:0]       remap;
    logic [31:0]       vector;
    logic [3:0][31:0]  hdr;
    logic [1:0]        hdr_idx;
    logic              hdr_busy;
    logic              hdr_rd;
    logic [3:0]        hdr_addr;
    logic              core_clk_en;
    logic              boot_rom;
    psbs_pwr_s         pwr;
    psbs_fuse_s        fuse;
    logic              fuse_rd_pend;
    logic              fuse_rd_val;
    logic [31:0]       rdata;
  } psbs_st_s;

endpackage

// ==== verilog/psbs_sequencer.sv ====
// Power state, wake and boot sequencer with SRAM retention and fuse port
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module psbs_sequencer (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  input  wire logic                cpu_wfi,
  input  wire logic                irq_pend,
  input  wire logic                evt_pend,
  input  wire logic                pin_wake,
  input  wire logic                rtc_wake,
  input  wire logic                ext_rst_wake,
  input  wire logic                uvlo_wake,
  input  wire logic                probe_test_variant,
  output logic                     core_clk_en,
  output logic                     boot_from_rom,
  output logic                     first_boot_rom_at_zero,
  output psbs_pkg::psbs_pwr_s      pwr_ctrl,
  output logic [3:0]               flash_hdr_addr,
  output logic                     flash_hdr_rd,
  input  wire logic [31:0]         flash_hdr_rdata,
  output psbs_pkg::psbs_fuse_s     fuse_ctrl,
  input  wire logic                fuse_rd_bit
);
  import psbs_pkg::*;

  psbs_st_s st_r;
  psbs_st_s st_nxt;
  logic     cg_wake;
  logic     sleep_wake;
  logic     off_wake;
  logic [3:0] hdr_off;

  always_comb begin
    unique case (st_r.hdr_idx)
      2'h0: hdr_off = HDR_MODE;
      2'h1: hdr_off = HDR_BASE;
      2'h2: hdr_off = HDR_LEN;
      default: hdr_off = HDR_BOOT;
    endcase
  end

  assign cg_wake    = (irq_pend & st_r.cg_mask[0]) | (evt_pend & st_r.cg_mask[1]);
  assign sleep_wake = |st_r.wk;
  assign off_wake   = st_r.wk[WK_PIN] | st_r.wk[WK_RST] | st_r.wk[WK_UVLO];

  always_comb begin
    st_nxt = st_r;
    st_nxt.fuse.strobe = 1'b0;
    st_nxt.rdata = 32'h0000_0000;
    // Pin synchroniser; a change counts once stages two and three agree
    st_nxt.s1 = {uvlo_wake, ext_rst_wake, rtc_wake, pin_wake};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.wk = st_r.s3;
    end
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.probe = probe_test_variant;
    end

    // Fuse read bit taken in the strobe cycle; a new read request wins
    if (st_r.fuse_rd_pend) begin
      st_nxt.fuse_rd_pend = 1'b0;
      st_nxt.fuse_rd_val = fuse_rd_bit;
    end

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        OFF_CTRL: begin
          st_nxt.keep_slow = reg_wdata[CTRL_SLOW];
          st_nxt.keep_rtc = reg_wdata[CTRL_RTC];
        end
        OFF_CG_MASK: st_nxt.cg_mask = reg_wdata[1:0];
        OFF_RET_EN: st_nxt.ret_en = reg_wdata[4:0];
        OFF_PWR_EN: st_nxt.pwr_en = reg_wdata[5:0];
        OFF_MODE: st_nxt.mode = reg_wdata;
        OFF_REMAP: st_nxt.remap = reg_wdata;
        OFF_VECTOR: st_nxt.vector = reg_wdata;
        OFF_FUSE: begin
          if (reg_wdata[FUSE_PROG]) begin
            st_nxt.fuse.strobe = 1'b1;
            st_nxt.fuse.prog = 1'b1;
            st_nxt.fuse.addr = reg_wdata[15:8];
            st_nxt.fuse.wdata = reg_wdata[FUSE_DATA];
          end else if (reg_wdata[FUSE_READ]) begin
            st_nxt.fuse.strobe = 1'b1;
            st_nxt.fuse.prog = 1'b0;
            st_nxt.fuse.addr = reg_wdata[15:8];
            st_nxt.fuse.wdata = 1'b0;
            st_nxt.fuse_rd_pend = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // Register reads, data one cycle later
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_CTRL: st_nxt.rdata = {28'h0, st_r.keep_rtc, st_r.keep_slow, 2'h0};
        OFF_CG_MASK: st_nxt.rdata = {30'h0, st_r.cg_mask};
        OFF_RET_EN: st_nxt.rdata = {27'h0, st_r.ret_en};
        OFF_PWR_EN: st_nxt.rdata = {26'h0, st_r.pwr_en};
        OFF_MODE: st_nxt.rdata = st_r.mode;
        OFF_REMAP: st_nxt.rdata = st_r.remap;
        OFF_VECTOR: st_nxt.rdata = st_r.vector;
        OFF_STATUS: st_nxt.rdata = {18'h0, st_r.wk, st_r.wake_pend, st_r.probe,
                                    st_r.hdr_busy, st_r.boot_rom, st_r.state};
        OFF_FUSE: st_nxt.rdata = {15'h0, st_r.fuse_rd_val, 15'h0, st_r.fuse_rd_pend};
        OFF_HDR0: st_nxt.rdata = st_r.hdr[0];
        OFF_HDR0 + 8'h04: st_nxt.rdata = st_r.hdr[1];
        OFF_HDR0 + 8'h08: st_nxt.rdata = st_r.hdr[2];
        OFF_HDR0 + 8'h0c: st_nxt.rdata = st_r.hdr[3];
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Sequencer
    unique case (st_r.state)
      ST_NORMAL: begin
        if (reg_wr && reg_addr == OFF_CTRL &&
            (reg_wdata[CTRL_SLEEP] || reg_wdata[CTRL_OFF])) begin
          st_nxt.state = ST_ENTER;
          st_nxt.off_sel = reg_wdata[CTRL_OFF];
          st_nxt.cnt = ENTER_CNT;
          st_nxt.wake_pend = 1'b0;
          st_nxt.core_clk_en = 1'b0;
        end else if (cpu_wfi) begin
          st_nxt.state = ST_CGATE;
          st_nxt.core_clk_en = 1'b0;
        end
      end
      ST_CGATE: begin
        if (cg_wake) begin
          st_nxt.state = ST_NORMAL;
          st_nxt.core_clk_en = 1'b1;
        end
      end
      ST_ENTER: begin
        if (st_r.off_sel ? off_wake : sleep_wake) begin
          st_nxt.wake_pend = 1'b1;
        end
        if (st_r.cnt == 3'h0) begin
          st_nxt.state = st_r.off_sel ? ST_OFF : ST_SLEEP;
        end else begin
          st_nxt.cnt = st_r.cnt - 3'h1;
        end
      end
      ST_SLEEP, ST_OFF: begin
        st_nxt.wake_pend = 1'b0;
        if (st_r.wake_pend ||
            (st_r.state == ST_SLEEP ? sleep_wake : off_wake)) begin
          st_nxt.state = ST_BOOT;
          st_nxt.boot_rom = 1'b1;
          st_nxt.core_clk_en = 1'b1;
          st_nxt.hdr_busy = 1'b1;
          st_nxt.hdr_idx = 2'h0;
        end
      end
      ST_BOOT: begin
        if (st_r.hdr_rd) begin
          st_nxt.hdr_rd = 1'b0;
          st_nxt.hdr_addr = 4'h0;
          st_nxt.hdr[st_r.hdr_idx] = flash_hdr_rdata;
          st_nxt.hdr_idx = st_r.hdr_idx + 2'h1;
          st_nxt.hdr_busy = (st_r.hdr_idx != 2'h3);
        end else if (st_r.hdr_busy) begin
          st_nxt.hdr_rd = 1'b1;
          st_nxt.hdr_addr = hdr_off;
        end else if (reg_wr && reg_addr == OFF_CTRL && reg_wdata[CTRL_DONE]) begin
          st_nxt.state = ST_NORMAL;
          st_nxt.boot_rom = 1'b0;
        end
      end
      default: st_nxt.state = ST_BOOT;
    endcase

    // Supplies and switches follow the next state
    st_nxt.pwr.low_dropout_regulator = (st_nxt.state != ST_OFF);
    if (st_nxt.state == ST_SLEEP || st_nxt.state == ST_OFF) begin
      st_nxt.pwr.fast_rc_oscillator = 1'b0;
      st_nxt.pwr.bandgap = 1'b0;
      st_nxt.pwr.slow_rc_oscillator = (st_nxt.state == ST_SLEEP) & st_r.keep_slow;
      st_nxt.pwr.rtc = (st_nxt.state == ST_SLEEP) & st_r.keep_rtc;
      st_nxt.pwr.domain_on = '0;
    end else begin
      st_nxt.pwr.fast_rc_oscillator = 1'b1;
      st_nxt.pwr.bandgap = 1'b1;
      st_nxt.pwr.slow_rc_oscillator = 1'b1;
      st_nxt.pwr.rtc = 1'b1;
      st_nxt.pwr.domain_on = st_nxt.pwr_en;
      st_nxt.pwr.domain_on[0] = st_nxt.pwr_en[0] | (st_nxt.state == ST_BOOT);
    end
    for (int i = 0; i < SRAM_BLOCKS; i++) begin
      if (st_nxt.state == ST_OFF) begin
        st_nxt.pwr.sram_supply[i] = SUP_OFF;
      end else if (st_nxt.state == ST_SLEEP) begin
        st_nxt.pwr.sram_supply[i] = st_r.ret_en[i] ? SUP_RET : SUP_OFF;
      end else begin
        st_nxt.pwr.sram_supply[i] = SUP_FULL;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '{state: ST_BOOT, cnt: 3'h0, wake_pend: 1'b0, off_sel: 1'b0,
                s1: 4'h0, s2: 4'h0, s3: 4'h0, wk: 4'h0, strap_done: 1'b0,
                probe: 1'b0, cg_mask: RST_CG_MASK, keep_slow: 1'b0,
                keep_rtc: 1'b0, ret_en: RST_RET_EN, pwr_en: RST_PWR_EN,
                mode: 32'h0, remap: 32'h0, vector: 32'h0, hdr: '0,
                hdr_idx: 2'h0, hdr_busy: 1'b1, hdr_rd: 1'b0, hdr_addr: 4'h0,
                core_clk_en: 1'b1, boot_rom: 1'b1,
                pwr: '{fast_rc_oscillator: 1'b1, slow_rc_oscillator: 1'b1,
                       bandgap: 1'b1, low_dropout_regulator: 1'b1, rtc: 1'b1,
                       sram_supply: {SRAM_BLOCKS{SUP_FULL}},
                       domain_on: RST_PWR_EN},
                fuse: '0, fuse_rd_pend: 1'b0, fuse_rd_val: 1'b0,
                rdata: 32'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata              = st_r.rdata;
  assign core_clk_en            = st_r.core_clk_en;
  assign boot_from_rom          = st_r.boot_rom;
  assign first_boot_rom_at_zero = st_r.probe;
  assign pwr_ctrl               = st_r.pwr;
  assign flash_hdr_addr         = st_r.hdr_addr;
  assign flash_hdr_rd           = st_r.hdr_rd;
  assign fuse_ctrl              = st_r.fuse;

  // Checks
  sequence s_entry_done;
    (st_r.state == ST_ENTER) && (st_r.cnt == 3'h0) && st_r.wake_pend;
  endsequence

  sequence s_low_then_boot;
    (st_r.state inside {ST_SLEEP, ST_OFF}) ##1 (st_r.state == ST_BOOT && st_r.boot_rom);
  endsequence

  property p_cg_enter;
    @(posedge clock) disable iff (sys_rst)
      (st_r.state == ST_NORMAL && cpu_wfi && !reg_wr)
        |=> (st_r.state == ST_CGATE) && !core_clk_en;
  endproperty
  a_cg_enter: assert property (p_cg_enter) else $error("wfi did not gate clock");

  property p_cg_resume;
    @(posedge clock) disable iff (sys_rst)
      (st_r.state == ST_CGATE && cg_wake)
        |=> (st_r.state == ST_NORMAL) && core_clk_en && !boot_from_rom;
  endproperty
  a_cg_resume: assert property (p_cg_resume) else $error("clock gate resume wrong");

  property p_cg_masked;
    @(posedge clock) disable iff (sys_rst)
      (st_r.state == ST_CGATE && !(irq_pend && st_r.cg_mask[0])
       && !(evt_pend && st_r.cg_mask[1])) |=> (st_r.state == ST_CGATE);
  endproperty
  a_cg_masked: assert property (p_cg_masked) else $error("masked source woke core");

  property p_sleep_rtc;
    @(posedge clock) disable iff (sys_rst)
      (st_r.state == ST_SLEEP && st_r.wk[WK_RTC]) |=> (st_r.state == ST_BOOT);
  endproperty
  a_sleep_rtc: assert property (p_sleep_rtc) else $error("rtc failed to wake sleep");

  property p_off_no_rtc;
    @(posedge clock) disable iff (sys_rst)
      (st_r.state == ST_OFF && !st_r.wake_pend && st_r.wk == 4'h2) |=> (st_r.state == ST_OFF);
  endproperty
  a_off_no_rtc: assert property (p_off_no_rtc) else $error("rtc woke off state");

  property p_wake_boot;
    @(posedge clock) disable iff (sys_rst)
      (st_r.state inside {ST_SLEEP, ST_OFF}) ##1 (st_r.state == ST_BOOT)
        |-> boot_from_rom && core_clk_en && pwr_ctrl.fast_rc_oscillator;
  endproperty
  a_wake_boot: assert property (p_wake_boot) else $error("wake did not enter boot");

  property p_pend_wake;
    @(posedge clock) disable iff (sys_rst)
      s_entry_done |=> s_low_then_boot;
  endproperty
  a_pend_wake: assert property (p_pend_wake) else $error("pending wake lost");

  property p_sleep_pwr;
    @(posedge clock) disable iff (sys_rst)
      (st_r.state == ST_SLEEP) |-> !pwr_ctrl.fast_rc_oscillator && !pwr_ctrl.bandgap
        && pwr_ctrl.low_dropout_regulator && (pwr_ctrl.rtc == st_r.keep_rtc)
        && (pwr_ctrl.sram_supply[0] == (st_r.ret_en[0] ? SUP_RET : SUP_OFF));
  endproperty
  a_sleep_pwr: assert property (p_sleep_pwr) else $error("sleep switches wrong");

  property p_fuse_read;
    @(posedge clock) disable iff (sys_rst)
      (reg_wr && reg_addr == OFF_FUSE && !reg_wdata[FUSE_PROG] && reg_wdata[FUSE_READ])
        |=> fuse_ctrl.strobe && !fuse_ctrl.prog ##1 !fuse_ctrl.strobe
            && (st_r.fuse_rd_val == $past(fuse_rd_bit));
  endproperty
  a_fuse_read: assert property (p_fuse_read) else $error("fuse read sequence wrong");

  property p_enter;
    @(posedge clock) disable iff (sys_rst)
      (st_r.state == ST_NORMAL && reg_wr && reg_addr == OFF_CTRL
       && (reg_wdata[CTRL_SLEEP] || reg_wdata[CTRL_OFF]))
        |=> (st_r.state == ST_ENTER) && !core_clk_en;
  endproperty
  a_enter: assert property (p_enter) else $error("sleep request not taken");

  property p_off_pwr;
    @(posedge clock) disable iff (sys_rst)
      (st_r.state == ST_OFF) |-> !pwr_ctrl.low_dropout_regulator && !pwr_ctrl.rtc
        && !pwr_ctrl.slow_rc_oscillator && (pwr_ctrl.sram_supply == '0);
  endproperty
  a_off_pwr: assert property (p_off_pwr) else $error("off state supplies wrong");

  property p_normal_pwr;
    @(posedge clock) disable iff (sys_rst)
      (st_r.state == ST_NORMAL) |-> (pwr_ctrl.domain_on == st_r.pwr_en)
        && (pwr_ctrl.sram_supply == {SRAM_BLOCKS{SUP_FULL}});
  endproperty
  a_normal_pwr: assert property (p_normal_pwr) else $error("normal supplies wrong");

  property p_hdr_pulse;
    @(posedge clock) disable iff (sys_rst)
      flash_hdr_rd |-> (flash_hdr_addr == {st_r.hdr_idx, 2'h0}) ##1 !flash_hdr_rd;
  endproperty
  a_hdr_pulse: assert property (p_hdr_pulse) else $error("header read wrong");

  property p_probe_hold;
    @(posedge clock) disable iff (sys_rst)
      st_r.strap_done |=> $stable(first_boot_rom_at_zero);
  endproperty
  a_probe_hold: assert property (p_probe_hold) else $error("probe alias changed");

endmodule // psbs_sequencer

// ==== testbench/psbs_far_end.sv ====
// Far-end model: flash header store and serial fuse array
`timescale 1ns/1ns
module psbs_far_end #(
  parameter logic [127:0] HDR = 128'h0
) (
  input  wire logic                 clock,
  input  wire logic [3:0]           flash_hdr_addr,
  input  wire logic                 flash_hdr_rd,
  input  wire psbs_pkg::psbs_fuse_s fuse_ctrl,
  output logic [31:0]               flash_hdr_rdata,
  output logic                      fuse_rd_bit
);
  import psbs_pkg::*;
  logic [255:0] fuse_mem  = '0;
  logic [31:0]  hdr_idle  = 32'h0;
  logic         fuse_idle = 1'b0;
  // Answers in the cycle of the request; idle lines keep toggling
  always @(posedge clock) begin
    hdr_idle <= ~hdr_idle;
    fuse_idle <= ~fuse_idle;
    if (fuse_ctrl.strobe && fuse_ctrl.prog)
      fuse_mem[fuse_ctrl.addr] <= fuse_ctrl.wdata;
  end
  assign flash_hdr_rdata = flash_hdr_rd ? HDR[flash_hdr_addr[3:2]*32 +: 32] : hdr_idle;
  assign fuse_rd_bit = (fuse_ctrl.strobe && !fuse_ctrl.prog) ?
                       fuse_mem[fuse_ctrl.addr] : fuse_idle;
endmodule // psbs_far_end

// ==== testbench/psbs_sequencer_tb.sv ====
// Testbench of the power state and boot sequencer
`timescale 1ns/1ns
module psbs_sequencer_tb;
  import psbs_pkg::*;
  localparam logic [127:0] HDR = 128'h0000_0001_0000_4000_1100_0000_5a5a_0001;
  localparam logic [4:0] RET = 5'h15;
  logic clock, sys_rst, reg_wr, reg_rd, cpu_wfi, irq_pend, evt_pend;
  logic pin_wake, rtc_wake, ext_rst_wake, uvlo_wake, probe_test_variant;
  logic core_clk_en, boot_from_rom, first_boot_rom_at_zero, flash_hdr_rd, fuse_rd_bit;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, flash_hdr_rdata, rd_v;
  logic [31:0] sav [3];
  logic [9:0]  es;
  logic [3:0]  flash_hdr_addr;
  psbs_pwr_s   pwr_ctrl;
  psbs_fuse_s  fuse_ctrl;
  int          errors, n_checks, i, j;

  psbs_sequencer DUT (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_wfi, .irq_pend, .evt_pend, .pin_wake, .rtc_wake, .ext_rst_wake, .uvlo_wake,
    .probe_test_variant, .core_clk_en, .boot_from_rom, .first_boot_rom_at_zero, .pwr_ctrl,
    .flash_hdr_addr, .flash_hdr_rd, .flash_hdr_rdata, .fuse_ctrl, .fuse_rd_bit);
  psbs_far_end #(.HDR(HDR)) far (.clock, .flash_hdr_addr, .flash_hdr_rd, .fuse_ctrl,
    .flash_hdr_rdata, .fuse_rd_bit);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd_v = reg_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_v, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic st(input psbs_state_e s);
    rd(OFF_STATUS);
    chk({26'h0, rd_v[5:0]}, {26'h0, s});
  endtask
  task automatic wait_boot;
    int k;
    for (k = 0; k < 40 && boot_from_rom !== 1'b1; k++) @(negedge clock);
    if (boot_from_rom !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic boot_exit;
    int k;
    wait_boot();
    chk({31'h0, core_clk_en}, 32'h1);
    st(ST_BOOT);
    for (k = 0; k < 30; k++) begin
      rd(OFF_STATUS);
      if (rd_v[7] === 1'b0 && k > 2)
        break;
    end
    if (k == 30) begin
      errors++;
      finish_test();
    end
    for (k = 0; k < 4; k++) rchk(OFF_HDR0 + 8'(4 * k), HDR[k*32 +: 32]);
    for (k = 0; k < 3; k++) rchk(OFF_MODE + 8'(4 * k), sav[k]);
    wr(OFF_CTRL, 32'h10);
    cyc(1);
    chk({30'h0, boot_from_rom, core_clk_en}, 32'h1);
    chk(32'(pwr_ctrl.sram_supply), 32'h2aa);
  endtask
  task automatic enter(input logic [31:0] c);
    wr(OFF_CTRL, c);
    cyc(0);
    chk({31'h0, core_clk_en}, 32'h0);
    cyc(5);
    st(c[1] ? ST_OFF : ST_SLEEP);
    for (int b = 0; b < 5; b++) es[2*b +: 2] = (!c[1] && RET[b]) ? SUP_RET : SUP_OFF;
    chk(32'(pwr_ctrl.sram_supply), 32'(es));
    chk({27'h0, pwr_ctrl[20:16]}, c[1] ? 32'h0 : 32'h0a);
  endtask

  initial begin
    #900000;
    errors++;
    finish_test();
  end

  initial begin
    errors = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    {reg_wr, reg_rd, cpu_wfi, irq_pend, evt_pend} = 5'h0;
    {uvlo_wake, ext_rst_wake, rtc_wake, pin_wake} = 4'h0;
    probe_test_variant = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    for (i = 0; i < 3; i++) sav[i] = 32'h0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    cyc(3);
    chk({29'h0, first_boot_rom_at_zero, boot_from_rom, core_clk_en}, 32'h7);
    chk(32'(pwr_ctrl.domain_on), 32'h3f);
    rchk(OFF_CG_MASK, 32'h3);
    rchk(OFF_RET_EN, 32'h0);
    rchk(OFF_PWR_EN, 32'h3f);
    cyc(0);
    chk(reg_rdata, 32'h0);
    rchk(8'h80, 32'h0);
    boot_exit();
    $display("test reset_boot done");
    wr(OFF_PWR_EN, 32'h2a);
    cyc(1);
    chk(32'(pwr_ctrl.domain_on), 32'h2a);
    wr(OFF_RET_EN, 32'(RET));
    rchk(OFF_RET_EN, 32'(RET));
    for (i = 0; i < 3; i++) begin
      sav[i] = 32'h1234_5670 + 32'(i);
      wr(OFF_MODE + 8'(4 * i), sav[i]);
    end
    wr(OFF_PWR_EN, 32'h3f);
    $display("test registers done");
    for (i = 1; i < 3; i++) begin
      wr(OFF_CG_MASK, 32'(i));
      @(posedge clock);
      cpu_wfi <= 1'b1;
      @(posedge clock);
      cpu_wfi <= 1'b0;
      cyc(0);
      chk({31'h0, core_clk_en}, 32'h0);
      st(ST_CGATE);
      @(posedge clock);
      {evt_pend, irq_pend} <= 2'(3 - i);
      cyc(4);
      chk({31'h0, core_clk_en}, 32'h0);
      @(posedge clock);
      {evt_pend, irq_pend} <= 2'(i);
      cyc(2);
      chk({30'h0, boot_from_rom, core_clk_en}, 32'h1);
      @(posedge clock);
      {evt_pend, irq_pend} <= 2'h0;
      st(ST_NORMAL);
    end
    $display("test clock_gate done");
    for (j = 0; j < 2; j++) begin
      for (i = 0; i < 4; i++) begin
        enter(j == 1 ? 32'h2 : 32'h5);
        if (j == 1) begin
          if (i == 1)
            continue;
          @(posedge clock);
          rtc_wake <= 1'b1;
          cyc(8);
          st(ST_OFF);
        end
        @(posedge clock);
        {uvlo_wake, ext_rst_wake, rtc_wake, pin_wake} <= 4'(1 << i);
        wait_boot();
        @(posedge clock);
        {uvlo_wake, ext_rst_wake, rtc_wake, pin_wake} <= 4'h0;
        boot_exit();
      end
      st(ST_NORMAL);
    end
    $display("test sleep_off done");
    @(posedge clock);
    pin_wake <= 1'b1;
    wr(OFF_CTRL, 32'h1);
    pin_wake <= 1'b0;
    wait_boot();
    boot_exit();
    $display("test late_wake done");
    wr(OFF_FUSE, 32'h0001_0701);
    cyc(0);
    chk({21'h0, fuse_ctrl}, {21'h0, 1'b1, 1'b1, 8'h07, 1'b1});
    cyc(1);
    chk({31'h0, fuse_ctrl.strobe}, 32'h0);
    wr(OFF_FUSE, 32'h0000_0702);
    cyc(3);
    rchk(OFF_FUSE, 32'h0001_0000);
    wr(OFF_FUSE, 32'h0000_0802);
    cyc(3);
    rchk(OFF_FUSE, 32'h0);
    $display("test fuse done");
    @(posedge clock);
    sys_rst <= 1'b1;
    probe_test_variant <= 1'b0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    cyc(3);
    chk({29'h0, first_boot_rom_at_zero, boot_from_rom, core_clk_en}, 32'h3);
    rchk(OFF_MODE, 32'h0);
    $display("test second_reset done");
    finish_test();
  end
endmodule // psbs_sequencer_tb
